/* File: include/cidsf_map.svh */
// Register offsets, field positions and reset values of the caller-id status block
`ifndef CIDSF_MAP_SVH
`define CIDSF_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (index on the 3-bit register port)
// ----------------------------------------------------------------------
`define CIDSF_OFF_LIVE 3'h0
`define CIDSF_OFF_FLAG 3'h1
`define CIDSF_OFF_MASK 3'h2
`define CIDSF_OFF_CTRL 3'h3
`define CIDSF_OFF_FSKB 3'h4

// ----------------------------------------------------------------------
// Live status bit positions
// ----------------------------------------------------------------------
`define CIDSF_BIT_CLK 6
`define CIDSF_BIT_VAL 5
`define CIDSF_BIT_CAR 4
`define CIDSF_BIT_TONE 3
`define CIDSF_BIT_BYTE 2
`define CIDSF_BIT_ALERT 1
`define CIDSF_BIT_RING 0

// ----------------------------------------------------------------------
// Event flag positions (same layout in flag and mask registers)
// ----------------------------------------------------------------------
`define CIDSF_EVT_LATCH 6
`define CIDSF_EVT_TONE 3
`define CIDSF_EVT_BYTE 2
`define CIDSF_EVT_ALERT 1
`define CIDSF_EVT_RING 0
`define CIDSF_EVT_USED 8'h4F

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define CIDSF_CTRL_EN 0
`define CIDSF_RST_LIVE 8'h00
`define CIDSF_RST_FLAG 8'h00
`define CIDSF_RST_MASK 8'h00
`define CIDSF_RST_CTRL 8'h00
`define CIDSF_RST_FSKB 8'h00

`endif

/* File: include/cidsf_pkg.sv */
// Shared types of the caller-id status block
package cidsf_pkg;
   // One register byte
   typedef logic [7:0] cidsf_byte_t;
   // Register port index
   typedef logic [2:0] cidsf_addr_t;
endpackage

/* File: rtl/cidsf_sync.sv */
// Two-stage synchroniser bank for detector inputs
`timescale 1ns/10ps
module cidsf_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Asynchronous inputs and their synchronised copies
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   // One pair of flip-flops per bit; stage one feeds stage two only
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               stage1_reg[gi] <= 1'b0;
               stage2_reg[gi] <= 1'b0;
            end else begin
               stage1_reg[gi] <= i_async[gi];
               stage2_reg[gi] <= stage1_reg[gi];
            end
         end
      end
   endgenerate

   assign o_sync = stage2_reg;
endmodule

/* File: rtl/cidsf_flags.sv */
// Sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/10ps
module cidsf_flags #(
   parameter int W = 8,
   parameter logic [7:0] USED = 8'hFF
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Hardware set pulses and software clear mask
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clr,
   // Flag state
   output logic [W-1:0] o_flags
);
   logic [W-1:0] flag_reg;
   logic [W-1:0] flag_next;

   // Next value per bit; a set in the clearing cycle wins so no event is lost
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_flag
         always_comb begin
            if (!USED[gi]) begin
               flag_next[gi] = 1'b0;
            end else if (i_set[gi]) begin
               flag_next[gi] = 1'b1;
            end else if (i_clr[gi]) begin
               flag_next[gi] = 1'b0;
            end else begin
               flag_next[gi] = flag_reg[gi];
            end
         end
      end
   endgenerate

   // Flag storage, empty after reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign o_flags = flag_reg;
endmodule

/* File: rtl/cidsf_top.sv */
// Caller-id live status, sticky event flags, mask, enable and received byte
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "cidsf_map.svh"

// What this block does
// - Live status read-only, zero at reset
// - Bit 6 mirrors FSK bit clock
// - Bit 5 mirrors FSK bit value
// - Bit 4 high while FSK carrier present
// - Bit 3 high while tone digit ready
// - Bit 2 high while FSK byte ready
// - Bit 1 high while qualified alert tone
// - Bit 0 high on ring or reversal
// - FSK latch clock rise sets sticky flag
// - Tone ready rise sets sticky flag
// - Byte ready rise sets sticky flag
// - Alert tone rise sets sticky flag
// - Ring rise sets sticky flag
// - Enable low blanks status and stops new flags; set flags are kept
// - Received byte held when byte ready
module cidsf_top #(
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire cidsf_pkg::cidsf_addr_t i_addr,
   input wire cidsf_pkg::cidsf_byte_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output cidsf_pkg::cidsf_byte_t o_rdata,
   // Detector signals, asynchronous to i_clk
   input wire logic i_fsk_bit_clock,
   input wire logic i_fsk_bit_value,
   input wire logic i_fsk_carrier_present,
   input wire logic i_tone_digit_ready,
   input wire logic i_fsk_byte_ready,
   input wire logic i_alert_tone_qualified,
   input wire logic i_ring_detected,
   input wire logic i_fsk_latch_clock,
   input wire logic [DW-1:0] i_fsk_received_byte,
   // Interrupt
   output logic o_irq
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam int NS = 8;
   logic [NS+DW-1:0] async_in;
   logic [NS+DW-1:0] sync_out;
   logic [NS-1:0] sync_bits;
   logic [DW-1:0] sync_data;
   cidsf_pkg::cidsf_byte_t live_status_reg;
   cidsf_pkg::cidsf_byte_t live_status_next;
   cidsf_pkg::cidsf_byte_t live_prev_reg;
   cidsf_pkg::cidsf_byte_t live_prev_next;
   logic latch_reg;
   logic latch_next;
   logic latch_prev_reg;
   logic latch_prev_next;
   cidsf_pkg::cidsf_byte_t ctrl_reg;
   cidsf_pkg::cidsf_byte_t ctrl_next;
   cidsf_pkg::cidsf_byte_t mask_reg;
   cidsf_pkg::cidsf_byte_t mask_next;
   logic [DW-1:0] fsk_byte_reg;
   logic [DW-1:0] fsk_byte_next;
   cidsf_pkg::cidsf_byte_t evt_set;
   cidsf_pkg::cidsf_byte_t evt_clr;
   cidsf_pkg::cidsf_byte_t flags;
   cidsf_pkg::cidsf_byte_t rdata_reg;
   cidsf_pkg::cidsf_byte_t rdata_next;
   logic irq_reg;
   logic irq_next;
   logic en;

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // Detector levels and byte bits all pass two flops before use
   always_comb begin
      async_in = '0;
      async_in[`CIDSF_BIT_CLK] = i_fsk_bit_clock;
      async_in[`CIDSF_BIT_VAL] = i_fsk_bit_value;
      async_in[`CIDSF_BIT_CAR] = i_fsk_carrier_present;
      async_in[`CIDSF_BIT_TONE] = i_tone_digit_ready;
      async_in[`CIDSF_BIT_BYTE] = i_fsk_byte_ready;
      async_in[`CIDSF_BIT_ALERT] = i_alert_tone_qualified;
      async_in[`CIDSF_BIT_RING] = i_ring_detected;
      async_in[7] = i_fsk_latch_clock; // Slot 7 carries the latch clock
      async_in[NS+DW-1:NS] = i_fsk_received_byte;
   end

   cidsf_sync #(
      .W(NS + DW)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(async_in),
      .o_sync(sync_out)
   );

   assign sync_bits = sync_out[NS-1:0];
   assign sync_data = sync_out[NS+DW-1:NS];
   assign en = ctrl_reg[`CIDSF_CTRL_EN];

   // ----------------------------------------------------------------------
   // Live status and edge detection
   // ----------------------------------------------------------------------
   // Hardware alone drives the live byte; bit 7 has no source and reads zero
   always_comb begin
      live_status_next = 8'h00;
      if (en) begin
         live_status_next[6:0] = sync_bits[6:0];
      end
      live_prev_next = live_status_reg;
      latch_next = en & sync_bits[7];
      latch_prev_next = latch_reg;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         live_status_reg <= `CIDSF_RST_LIVE;
         live_prev_reg <= `CIDSF_RST_LIVE;
         latch_reg <= 1'b0;
         latch_prev_reg <= 1'b0;
      end else begin
         live_status_reg <= live_status_next;
         live_prev_reg <= live_prev_next;
         latch_reg <= latch_next;
         latch_prev_reg <= latch_prev_next;
      end
   end

   // Rising edges against the previous sample feed the sticky flags
   always_comb begin
      evt_set = 8'h00;
      evt_set[`CIDSF_EVT_LATCH] = latch_reg & ~latch_prev_reg;
      evt_set[`CIDSF_EVT_TONE] = live_status_reg[`CIDSF_BIT_TONE]
         & ~live_prev_reg[`CIDSF_BIT_TONE];
      evt_set[`CIDSF_EVT_BYTE] = live_status_reg[`CIDSF_BIT_BYTE]
         & ~live_prev_reg[`CIDSF_BIT_BYTE];
      evt_set[`CIDSF_EVT_ALERT] = live_status_reg[`CIDSF_BIT_ALERT]
         & ~live_prev_reg[`CIDSF_BIT_ALERT];
      evt_set[`CIDSF_EVT_RING] = live_status_reg[`CIDSF_BIT_RING]
         & ~live_prev_reg[`CIDSF_BIT_RING];
      evt_clr = 8'h00;
      if (i_wr && (i_addr == `CIDSF_OFF_FLAG)) begin
         evt_clr = i_wdata; // Write one to clear
      end
   end

   // ----------------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------------
   cidsf_flags #(
      .W(8),
      .USED(`CIDSF_EVT_USED)
   ) u_flags (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_set(evt_set),
      .i_clr(evt_clr),
      .o_flags(flags)
   );

   // ----------------------------------------------------------------------
   // Control, mask and received byte
   // ----------------------------------------------------------------------
   // Enable starts low, so software must switch detection on after reset
   always_comb begin
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      fsk_byte_next = fsk_byte_reg;
      if (i_wr && (i_addr == `CIDSF_OFF_CTRL)) begin
         ctrl_next = 8'h00;
         ctrl_next[`CIDSF_CTRL_EN] = i_wdata[`CIDSF_CTRL_EN];
      end
      if (i_wr && (i_addr == `CIDSF_OFF_MASK)) begin
         mask_next = i_wdata & `CIDSF_EVT_USED;
      end
      // Data is caught with the ready edge, both delayed by the same synchroniser
      if (evt_set[`CIDSF_EVT_BYTE]) begin
         fsk_byte_next = sync_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= `CIDSF_RST_CTRL;
         mask_reg <= `CIDSF_RST_MASK;
         fsk_byte_reg <= DW'(`CIDSF_RST_FSKB);
      end else begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         fsk_byte_reg <= fsk_byte_next;
      end
   end

   // ----------------------------------------------------------------------
   // Read data and interrupt
   // ----------------------------------------------------------------------
   // Read data stands only in the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `CIDSF_OFF_LIVE: rdata_next = live_status_reg;
            `CIDSF_OFF_FLAG: rdata_next = flags;
            `CIDSF_OFF_MASK: rdata_next = mask_reg;
            `CIDSF_OFF_CTRL: rdata_next = ctrl_reg;
            `CIDSF_OFF_FSKB: rdata_next = 8'(fsk_byte_reg);
            default: rdata_next = 8'h00;
         endcase
      end
      irq_next = |(flags & mask_reg);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_irq = irq_reg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // Enable held long enough for a pin level to cross the synchroniser
   sequence s_en_held;
      en [*4];
   endsequence

   sequence s_tone_rise;
      $rose(live_status_reg[`CIDSF_BIT_TONE]);
   endsequence

   sequence s_ring_rise;
      !live_status_reg[`CIDSF_BIT_RING] ##1 live_status_reg[`CIDSF_BIT_RING];
   endsequence

   a_live_write_ignored: assert property (
      (i_wr && i_addr == `CIDSF_OFF_LIVE && !en) |=> live_status_reg == 8'h00)
      else $error("live status changed by a write");

   a_bit_clock_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_CLK] == $past(i_fsk_bit_clock, 3))
      else $error("bit clock not mirrored");

   a_bit_value_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_VAL] == $past(i_fsk_bit_value, 3))
      else $error("bit value not mirrored");

   a_carrier_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_CAR] == $past(i_fsk_carrier_present, 3))
      else $error("carrier not mirrored");

   a_tone_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_TONE] == $past(i_tone_digit_ready, 3))
      else $error("tone ready not mirrored");

   a_byte_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_BYTE] == $past(i_fsk_byte_ready, 3))
      else $error("byte ready not mirrored");

   a_alert_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_ALERT] == $past(i_alert_tone_qualified, 3))
      else $error("alert tone not mirrored");

   a_ring_mirror: assert property (
      s_en_held |-> live_status_reg[`CIDSF_BIT_RING] == $past(i_ring_detected, 3))
      else $error("ring not mirrored");

   a_latch_flag_set: assert property (
      (!latch_reg ##1 latch_reg) |=> flags[`CIDSF_EVT_LATCH])
      else $error("latch clock edge lost");

   a_tone_flag_set: assert property (
      s_tone_rise |=> flags[`CIDSF_EVT_TONE])
      else $error("tone edge lost");

   a_byte_flag_set: assert property (
      $rose(live_status_reg[`CIDSF_BIT_BYTE]) |=> flags[`CIDSF_EVT_BYTE])
      else $error("byte edge lost");

   a_alert_flag_set: assert property (
      $rose(live_status_reg[`CIDSF_BIT_ALERT]) |=> flags[`CIDSF_EVT_ALERT])
      else $error("alert edge lost");

   a_ring_flag_set: assert property (
      s_ring_rise |=> flags[`CIDSF_EVT_RING])
      else $error("ring edge lost");

   a_disabled_quiet: assert property (
      (!en) [*2] |-> live_status_reg == 8'h00 && !latch_reg)
      else $error("status active while disabled");

   a_byte_captured: assert property (
      $rose(live_status_reg[`CIDSF_BIT_BYTE]) |=> fsk_byte_reg == $past(sync_data))
      else $error("received byte not captured");

   a_set_beats_clear: assert property (
      (evt_set[`CIDSF_EVT_TONE] && evt_clr[`CIDSF_EVT_TONE]) |=> flags[`CIDSF_EVT_TONE])
      else $error("clear beat a set");

   a_flag_sticky: assert property (
      (flags[`CIDSF_EVT_TONE] && !evt_clr[`CIDSF_EVT_TONE]) |=> flags[`CIDSF_EVT_TONE])
      else $error("flag dropped without clear");

   a_irq_level: assert property (
      (|(flags & mask_reg)) |=> o_irq)
      else $error("interrupt not raised");

   a_read_window: assert property (
      (i_rd && i_addr == `CIDSF_OFF_LIVE) |=> o_rdata == $past(live_status_reg) ##1
      ($past(i_rd) || o_rdata == 8'h00))
      else $error("read data timing wrong");
endmodule

/* File: verification/cidsf_detector_model.sv */
// Behavioural model of the caller-id detectors that feed the status block
`timescale 1ns/10ps
module cidsf_detector_model (
   // Clock
   input wire logic i_clk,
   // Detector levels: bit 7 latch clock, bits 6..0 in live status order
   output logic [7:0] o_pins,
   // Demodulated byte
   output logic [7:0] o_byte
);
   // -------------------------------------------------------------------
   // Idle state of the detector lines
   // -------------------------------------------------------------------
   initial begin
      o_pins = 8'h00;
      o_byte = 8'h5A;
   end

   // Level changes land just after an edge and stand two cycles at least,
   // so the synchroniser cannot miss them
   task automatic set_pin(input int idx, input logic v);
      @(posedge i_clk);
      o_pins[idx] <= v;
      repeat (2) @(posedge i_clk);
   endtask

   // Byte settles before ready rises; once its hold has run out the
   // lines show the inverse, so a late capture cannot pass by luck
   task automatic deliver_byte(input logic [7:0] b);
      @(posedge i_clk);
      o_byte <= b;
      repeat (4) @(posedge i_clk);
      o_pins[2] <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_byte <= ~b;
   endtask
endmodule

/* File: verification/cidsf_top_test.sv */
// Self-checking testbench of the caller-id status and flag block
`timescale 1ns/10ps
`include "cidsf_map.svh"
module cidsf_top_test;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   cidsf_pkg::cidsf_addr_t i_addr = 3'h0;
   cidsf_pkg::cidsf_byte_t i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   cidsf_pkg::cidsf_byte_t o_rdata;
   logic o_irq;
   logic [7:0] pins;
   logic [7:0] rx_byte;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   // -------------------------------------------------------------------
   // Clock, design and detector model
   // -------------------------------------------------------------------
   always #4 i_clk = ~i_clk;

   cidsf_top dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_fsk_bit_clock(pins[6]), .i_fsk_bit_value(pins[5]),
      .i_fsk_carrier_present(pins[4]), .i_tone_digit_ready(pins[3]),
      .i_fsk_byte_ready(pins[2]), .i_alert_tone_qualified(pins[1]),
      .i_ring_detected(pins[0]), .i_fsk_latch_clock(pins[7]),
      .i_fsk_received_byte(rx_byte), .o_irq(o_irq)
   );

   cidsf_detector_model det_u (.i_clk(i_clk), .o_pins(pins), .o_byte(rx_byte));

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic print_verdict();
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input cidsf_pkg::cidsf_byte_t seen, input cidsf_pkg::cidsf_byte_t exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input cidsf_pkg::cidsf_addr_t a, input cidsf_pkg::cidsf_byte_t d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic reg_check(input cidsf_pkg::cidsf_addr_t a, input cidsf_pkg::cidsf_byte_t exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask

   // Synchroniser, edge detect and interrupt register all settle in this;
   // the step past the edge keeps later samples clear of the launch edge
   task automatic settle();
      repeat (6) @(posedge i_clk);
      #1;
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_reset_values();
      for (int a = 0; a < 8; a++) begin
         reg_check(a[2:0], 8'h00);
      end
      check({7'h00, o_irq}, 8'h00);
   endtask

   // With enable low nothing shows; the write to live status is ignored
   task automatic t_disabled();
      det_u.set_pin(3, 1'b1);
      settle();
      reg_check(`CIDSF_OFF_LIVE, 8'h00);
      reg_check(`CIDSF_OFF_FLAG, 8'h00);
      det_u.set_pin(3, 1'b0);
      reg_write(`CIDSF_OFF_LIVE, 8'hFF);
      reg_write(`CIDSF_OFF_CTRL, 8'h01);
      reg_check(`CIDSF_OFF_CTRL, 8'h01);
      reg_write(3'h5, 8'hFF);
      reg_check(3'h5, 8'h00);
      reg_check(`CIDSF_OFF_LIVE, 8'h00);
   endtask

   // Each of detector lines 0 to 6 alone reaches its own live bit, then drops
   task automatic t_live_mirror();
      for (int b = 0; b < 7; b++) begin
         det_u.set_pin(b, 1'b1);
         settle();
         reg_check(`CIDSF_OFF_LIVE, 8'h01 << b);
         det_u.set_pin(b, 1'b0);
         settle();
      end
      reg_check(`CIDSF_OFF_LIVE, 8'h00);
   endtask

   // Rises of ring, alert, byte and tone left four sticky flags; then a
   // clear lands in the very cycle of a tone rise and must lose to it
   task automatic t_sticky_clear();
      reg_check(`CIDSF_OFF_FLAG, 8'h0F);
      reg_write(`CIDSF_OFF_FLAG, 8'h02);
      reg_check(`CIDSF_OFF_FLAG, 8'h0D);
      reg_write(`CIDSF_OFF_FLAG, 8'hFF);
      reg_check(`CIDSF_OFF_FLAG, 8'h00);
      det_u.set_pin(3, 1'b1);
      reg_write(`CIDSF_OFF_FLAG, 8'h08);
      reg_check(`CIDSF_OFF_FLAG, 8'h08);
      reg_write(`CIDSF_OFF_FLAG, 8'h08);
      det_u.set_pin(3, 1'b0);
   endtask

   // A level held high after its rise must not set the flag again
   task automatic t_latch_edge();
      det_u.set_pin(7, 1'b1);
      settle();
      reg_check(`CIDSF_OFF_FLAG, 8'h40);
      reg_check(`CIDSF_OFF_LIVE, 8'h00);
      reg_write(`CIDSF_OFF_FLAG, 8'h40);
      settle();
      reg_check(`CIDSF_OFF_FLAG, 8'h00);
      det_u.set_pin(7, 1'b0);
      settle();
   endtask

   // Masked-out flag keeps the line low; unmasked one raises it
   task automatic t_interrupt();
      reg_write(`CIDSF_OFF_MASK, 8'h08);
      reg_check(`CIDSF_OFF_MASK, 8'h08);
      det_u.set_pin(0, 1'b1);
      settle();
      check({7'h00, o_irq}, 8'h00);
      det_u.set_pin(3, 1'b1);
      settle();
      check({7'h00, o_irq}, 8'h01);
      reg_write(`CIDSF_OFF_FLAG, 8'h08);
      settle();
      check({7'h00, o_irq}, 8'h00);
      reg_check(`CIDSF_OFF_FLAG, 8'h01);
      det_u.set_pin(0, 1'b0);
      det_u.set_pin(3, 1'b0);
   endtask

   // The byte is held after the lines have moved on
   task automatic t_received_byte();
      det_u.deliver_byte(8'hA5);
      settle();
      reg_check(`CIDSF_OFF_FSKB, 8'hA5);
      reg_check(`CIDSF_OFF_LIVE, 8'h04);
      reg_write(`CIDSF_OFF_FSKB, 8'h00);
      reg_check(`CIDSF_OFF_FSKB, 8'hA5);
      det_u.set_pin(2, 1'b0);
      reg_write(`CIDSF_OFF_CTRL, 8'h00);
      settle();
      reg_check(`CIDSF_OFF_FLAG, 8'h05);
   endtask

   // -------------------------------------------------------------------
   // Main sequence and hang guard
   // -------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset_values();
      t_disabled();
      t_live_mirror();
      t_sticky_clear();
      t_latch_edge();
      t_interrupt();
      t_received_byte();
      print_verdict();
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end
endmodule
